/* common/emif_cfg.svh */
`ifndef EMIF_CFG_SVH
`define EMIF_CFG_SVH

// Register byte offsets on the AXI4-Lite slave.
`define EMIF_OFS_CONFIG 8'h00
`define EMIF_OFS_BANK_PAGE 8'h04
`define EMIF_OFS_TIMING 8'h08
`define EMIF_OFS_STATUS 8'h0c

// Configuration register fields.
`define EMIF_CFG_ALE_LSB 0
`define EMIF_CFG_ALE_MSB 1
`define EMIF_CFG_MODE_LSB 2
`define EMIF_CFG_MODE_MSB 3
`define EMIF_CFG_MUX_BIT 4

// Timing control register fields.
`define EMIF_TC_HOLD_LSB 0
`define EMIF_TC_HOLD_MSB 1
`define EMIF_TC_PULSE_LSB 2
`define EMIF_TC_PULSE_MSB 5
`define EMIF_TC_SETUP_LSB 6
`define EMIF_TC_SETUP_MSB 7

// Reset values: setup, strobe and hold come up at their longest settings.
`define EMIF_RST_CONFIG 8'h03
`define EMIF_RST_BANK_PAGE 8'h00
`define EMIF_RST_TIMING 8'hff

// Size of the on-chip external-data RAM in bytes, and its address width.
`define EMIF_EXTERNAL_DATA_RAM_SIZE 17'h00800
`define EMIF_EXTERNAL_DATA_RAM_AW 11

// Fixed cycles added to every off-chip access: one address cycle and a tail.
`define EMIF_FIXED_CYCLES 4
`define EMIF_TAIL_LOAD 4'h2

// AXI responses.
`define EMIF_RESP_OKAY 2'h0
`define EMIF_RESP_SLVERR 2'h2

`endif

/* common/emif_pkg.sv */
package emif_pkg;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_LOCAL = 9'h002,
        ST_ADDR = 9'h004,
        ST_ALEH = 9'h008,
        ST_ALEL = 9'h010,
        ST_SETUP = 9'h020,
        ST_STROBE = 9'h040,
        ST_HOLD = 9'h080,
        ST_TAIL = 9'h100
    } state_t;

    typedef enum logic [1:0] {
        MODE_ONCHIP = 2'h0,
        MODE_SPLIT = 2'h1,
        MODE_SPLIT_BANK = 2'h2,
        MODE_EXTERNAL = 2'h3
    } mode_t;

endpackage

/* verif/emif_route_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module emif_route_assertions (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // CPU side
    input wire logic CPU_REQ,
    input wire logic CPU_READY,
    input wire logic CPU_DONE,
    // External bus
    input wire logic EXT_ADDR_LO_OE,
    input wire logic EXT_DATA_OE,
    input wire logic EXT_RD_N,
    input wire logic EXT_WR_N,
    input wire logic EXT_ALE
);
    logic [5:0] busy_q;
    logic [5:0] busy_d;
    logic off_q;
    logic off_d;
    logic mux_q;
    logic mux_d;
    logic [2:0] ale_q;
    logic [2:0] ale_d;

    // Busy length and the kind of access are tracked so the end pulse can be judged.
    always_comb begin
        busy_d = CPU_READY ? 6'h00 : busy_q + 6'h01;
        off_d = !CPU_READY && (off_q || !EXT_RD_N || !EXT_WR_N);
        mux_d = !CPU_READY && (mux_q || EXT_ALE);
        ale_d = EXT_ALE ? ale_q + 3'h1 : 3'h0;
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            busy_q <= 6'h00;
            off_q <= 1'b0;
            mux_q <= 1'b0;
            ale_q <= 3'h0;
        end else begin
            busy_q <= busy_d;
            off_q <= off_d;
            mux_q <= mux_d;
            ale_q <= ale_d;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    chk_idle_quiet: assert property (CPU_READY |-> EXT_RD_N && EXT_WR_N && !EXT_ALE)
        else $error("strobe or latch active while idle");
    chk_onchip_len: assert property (CPU_DONE && !off_q |-> busy_q == 6'h01)
        else $error("on-chip access length wrong");
    chk_min_plain: assert property (CPU_DONE && off_q && !mux_q |-> busy_q >= 6'h05)
        else $error("plain off-chip access too short");
    chk_min_mux: assert property (CPU_DONE && mux_q |-> busy_q >= 6'h07)
        else $error("multiplexed access too short");
    chk_done_pulse: assert property (CPU_DONE |=> !CPU_DONE)
        else $error("done longer than one cycle");
    chk_take_busy: assert property (CPU_REQ && CPU_READY |=> !CPU_READY)
        else $error("request not taken");
    chk_ale_width: assert property ($fell(EXT_ALE) |-> ale_q >= 3'h1 && ale_q <= 3'h4)
        else $error("latch pulse width out of range");
    chk_wr_data: assert property (!EXT_WR_N |-> EXT_DATA_OE)
        else $error("write strobe without data");
    chk_rd_addr: assert property (!EXT_RD_N && !mux_q |-> EXT_ADDR_LO_OE)
        else $error("read strobe without low address");
    chk_one_strobe: assert property (!(!EXT_RD_N && !EXT_WR_N))
        else $error("read and write strobes together");
endmodule
`default_nettype wire

/* verif/emif_route_bench.sv */
`timescale 1ns/1ps
`include "emif_cfg.svh"
`default_nettype none
module emif_route_bench;
    localparam logic [7:0] CFG = `EMIF_OFS_CONFIG;
    localparam logic [7:0] BANK = `EMIF_OFS_BANK_PAGE;
    localparam logic [7:0] TIM = `EMIF_OFS_TIMING;
    localparam logic [7:0] STAT = `EMIF_OFS_STATUS;
    localparam logic [1:0] OK = `EMIF_RESP_OKAY;
    localparam logic [1:0] ERR = `EMIF_RESP_SLVERR;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00, cpu_ptr = 8'h00, cpu_wdata = 8'h00;
    logic [31:0] w_data = 32'h0;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic cpu_req = 1'b0, cpu_write = 1'b0, cpu_wide = 1'b0;
    logic [15:0] cpu_dp = 16'h0000;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, cpu_ready, cpu_done;
    logic hi_oe, lo_oe, d_oe, rd_n, wr_n, ale, strobe, s_hoe, mux;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    logic [7:0] cpu_rdata, hi, lo, d_o, d_i, s_hi, s_lo;
    int n, num_errors = 0, comparisons = 0;

    always #12.5 CLOCK = ~CLOCK;

    emif_route emif_route_inst (.CLOCK(CLOCK), .RST_N(RST_N), .S_AXI_AWADDR(aw_addr),
        .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
        .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(r_ready), .CPU_REQ(cpu_req), .CPU_READY(cpu_ready),
        .CPU_WRITE(cpu_write), .CPU_WIDE(cpu_wide), .CPU_DATA_POINTER(cpu_dp),
        .CPU_INDIRECT_POINTER(cpu_ptr), .CPU_WDATA(cpu_wdata), .CPU_DONE(cpu_done),
        .CPU_RDATA(cpu_rdata), .EXT_ADDR_HI(hi), .EXT_ADDR_HI_OE(hi_oe), .EXT_ADDR_LO(lo),
        .EXT_ADDR_LO_OE(lo_oe), .EXT_DATA_O(d_o), .EXT_DATA_OE(d_oe), .EXT_DATA_I(d_i),
        .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .EXT_ALE(ale));

    ext_memory_model ext_memory_model_inst (.clock(CLOCK), .addr_lo(lo), .addr_lo_oe(lo_oe),
        .data_o(d_o), .data_oe(d_oe), .data_i(d_i), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic timeout_if(input bit ok);
        if (!ok) begin
            num_errors++;
            report_and_stop();
        end
    endtask

    function automatic logic [7:0] cfg(input logic m, input logic [1:0] md, input logic [1:0] a);
        return {3'h0, m, md, a};
    endfunction

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        bit ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        ok = 1'b0;
        @(posedge CLOCK);
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= {24'h000000, d};
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        for (int i = 0; i < 50 && !(aw_ok && w_ok); i++) begin
            @(negedge CLOCK);
            aw_ok = aw_ok || aw_ready;
            w_ok = w_ok || w_ready;
            @(posedge CLOCK);
            if (aw_ok) aw_valid <= 1'b0;
            if (w_ok) w_valid <= 1'b0;
        end
        timeout_if(aw_ok && w_ok);
        for (int i = 0; i < 50 && !ok; i++) begin
            @(negedge CLOCK);
            ok = b_valid;
        end
        timeout_if(ok);
        check({30'h0, b_resp}, {30'h0, er});
        @(posedge CLOCK);
        b_ready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        bit ok;
        ok = 1'b0;
        @(posedge CLOCK);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(negedge CLOCK);
            ok = ar_ready;
        end
        timeout_if(ok);
        @(posedge CLOCK);
        ar_valid <= 1'b0;
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(negedge CLOCK);
            ok = r_valid;
        end
        timeout_if(ok);
        check({30'h0, r_resp}, {30'h0, er});
        check(r_data, {24'h0, ed});
        @(posedge CLOCK);
        r_ready <= 1'b0;
    endtask

    task automatic move_chk(input logic wr, input logic wide, input logic [15:0] dp,
            input logic [7:0] ptr, input logic [7:0] wd, input int en, input logic eh,
            input logic [15:0] ea, input logic [7:0] erd);
        bit ok;
        ok = 1'b0;
        n = 0;
        strobe = 1'b0;
        @(posedge CLOCK);
        cpu_req <= 1'b1;
        cpu_write <= wr;
        cpu_wide <= wide;
        cpu_dp <= dp;
        cpu_ptr <= ptr;
        cpu_wdata <= wd;
        @(posedge CLOCK);
        cpu_req <= 1'b0;
        for (int i = 0; i < 60 && !ok; i++) begin
            @(posedge CLOCK);
            #1;
            ok = cpu_done;
            n++;
            if (!rd_n || !wr_n) begin
                strobe = 1'b1;
                s_hoe = hi_oe;
                s_hi = hi;
                s_lo = lo;
            end
        end
        timeout_if(ok);
        check(32'(n), 32'(en));
        check(32'(strobe), 32'(en > 1));
        if (en > 1) begin
            check(32'(s_hoe), 32'(eh));
            if (eh) check(32'(s_hi), 32'(ea[15:8]));
            if (!mux) check(32'(s_lo), 32'(ea[7:0]));
        end
        if (!wr) check(32'(cpu_rdata), 32'(erd));
    endtask

    task automatic test_reset();
        axi_read(CFG, `EMIF_RST_CONFIG, OK);
        axi_read(TIM, `EMIF_RST_TIMING, OK);
        axi_read(BANK, `EMIF_RST_BANK_PAGE, OK);
        axi_read(STAT, 8'h00, OK);
        axi_read(8'h10, 8'h00, ERR);
        axi_write(8'h10, 8'h55, ERR);
        move_chk(1'b1, 1'b1, 16'h1234, 8'h00, 8'h42, 1, 1'b0, 16'h0000, 8'h00);
        move_chk(1'b0, 1'b1, 16'h1234, 8'h00, 8'h00, 1, 1'b0, 16'h0000, 8'h42);
        $display("reset values test done");
    endtask

    task automatic test_split_bank();
        axi_write(CFG, cfg(1'b0, emif_pkg::MODE_SPLIT_BANK, 2'h0), OK);
        axi_write(TIM, 8'h00, OK);
        axi_write(BANK, 8'h12, OK);
        move_chk(1'b1, 1'b0, 16'h0000, 8'h34, 8'ha5, 5, 1'b1, 16'h1234, 8'h00);
        move_chk(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00, 5, 1'b1, 16'h1234, 8'ha5);
        axi_read(STAT, 8'h01, OK);
        axi_write(BANK, 8'h00, OK);
        move_chk(1'b1, 1'b0, 16'h0000, 8'h34, 8'h3c, 1, 1'b0, 16'h0000, 8'h00);
        move_chk(1'b1, 1'b1, 16'h07ff, 8'h00, 8'h66, 1, 1'b0, 16'h0000, 8'h00);
        move_chk(1'b0, 1'b1, 16'h0034, 8'h00, 8'h00, 1, 1'b0, 16'h0000, 8'h3c);
        move_chk(1'b1, 1'b1, 16'h0800, 8'h00, 8'h99, 5, 1'b1, 16'h0800, 8'h00);
        $display("split mode with bank test done");
    endtask

    task automatic test_ext_only();
        axi_write(BANK, 8'h12, OK);
        axi_write(CFG, cfg(1'b0, emif_pkg::MODE_SPLIT, 2'h0), OK);
        move_chk(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00, 5, 1'b0, 16'h0034, 8'ha5);
        axi_write(CFG, cfg(1'b0, emif_pkg::MODE_EXTERNAL, 2'h0), OK);
        move_chk(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00, 5, 1'b0, 16'h0034, 8'ha5);
        move_chk(1'b0, 1'b1, 16'h0034, 8'h00, 8'h00, 5, 1'b1, 16'h0034, 8'ha5);
        $display("external only test done");
    endtask

    task automatic test_timing();
        axi_write(TIM, 8'hff, OK);
        move_chk(1'b1, 1'b1, 16'h1234, 8'h00, 8'h5a, 26, 1'b1, 16'h1234, 8'h00);
        axi_write(TIM, 8'h44, OK);
        move_chk(1'b0, 1'b1, 16'h1234, 8'h00, 8'h00, 7, 1'b1, 16'h1234, 8'h5a);
        axi_write(TIM, 8'h03, OK);
        move_chk(1'b0, 1'b1, 16'h0034, 8'h00, 8'h00, 8, 1'b1, 16'h0034, 8'h5a);
        $display("timing test done");
    endtask

    task automatic test_mux();
        mux = 1'b1;
        axi_write(TIM, 8'h00, OK);
        axi_write(CFG, cfg(1'b1, emif_pkg::MODE_EXTERNAL, 2'h0), OK);
        move_chk(1'b1, 1'b1, 16'h0850, 8'h00, 8'h77, 7, 1'b1, 16'h0850, 8'h00);
        move_chk(1'b0, 1'b1, 16'h0850, 8'h00, 8'h00, 7, 1'b1, 16'h0850, 8'h77);
        axi_write(CFG, cfg(1'b1, emif_pkg::MODE_EXTERNAL, 2'h3), OK);
        move_chk(1'b0, 1'b1, 16'h0850, 8'h00, 8'h00, 13, 1'b1, 16'h0850, 8'h77);
        $display("multiplexed test done");
    endtask

    initial begin
        mux = 1'b0;
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        test_reset();
        test_split_bank();
        test_ext_only();
        test_timing();
        test_mux();
        report_and_stop();
    end
endmodule

bind emif_route emif_route_assertions emif_route_assertions_inst (.CLOCK(CLOCK),
    .RST_N(RST_N), .CPU_REQ(CPU_REQ), .CPU_READY(CPU_READY), .CPU_DONE(CPU_DONE),
    .EXT_ADDR_LO_OE(EXT_ADDR_LO_OE), .EXT_DATA_OE(EXT_DATA_OE), .EXT_RD_N(EXT_RD_N),
    .EXT_WR_N(EXT_WR_N), .EXT_ALE(EXT_ALE));
`default_nettype wire

/* verif/ext_memory_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model (
    // Clock
    input wire logic clock,
    // Bus pins as the memory sees them
    input wire logic [7:0] addr_lo,
    input wire logic addr_lo_oe,
    input wire logic [7:0] data_o,
    input wire logic data_oe,
    output logic [7:0] data_i,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale
);
    logic [7:0] mem [0:255];
    logic [7:0] latch_q = 8'h00;
    logic [7:0] idle_q = 8'h5a;
    logic [7:0] addr;

    // In multiplexed mode the low byte lives only in the external latch.
    assign addr = addr_lo_oe ? addr_lo : latch_q;
    // A released bus toggles so that stale data never passes for a read.
    assign data_i = !rd_n ? mem[addr] : idle_q;
    always @(posedge clock) idle_q <= ~idle_q;
    always @(negedge ale) latch_q <= data_o;
    always @(posedge clock) if (!wr_n && data_oe) mem[addr] <= data_o;
endmodule
`default_nettype wire

/* verilog/emif_route.sv */
`timescale 1ns/1ps
`include "emif_cfg.svh"
`default_nettype none

module emif_route (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // CPU external move port
    input wire logic CPU_REQ,
    output logic CPU_READY,
    input wire logic CPU_WRITE,
    input wire logic CPU_WIDE,
    input wire logic [15:0] CPU_DATA_POINTER,
    input wire logic [7:0] CPU_INDIRECT_POINTER,
    input wire logic [7:0] CPU_WDATA,
    output logic CPU_DONE,
    output logic [7:0] CPU_RDATA,
    // External parallel bus
    output logic [7:0] EXT_ADDR_HI,
    output logic EXT_ADDR_HI_OE,
    output logic [7:0] EXT_ADDR_LO,
    output logic EXT_ADDR_LO_OE,
    output logic [7:0] EXT_DATA_O,
    output logic EXT_DATA_OE,
    input wire logic [7:0] EXT_DATA_I,
    output logic EXT_RD_N,
    output logic EXT_WR_N,
    output logic EXT_ALE
);

    function automatic logic offset_known(input logic [7:0] a);
        offset_known = (a[7:2] == `EMIF_OFS_CONFIG >> 2) || (a[7:2] == `EMIF_OFS_BANK_PAGE >> 2)
            || (a[7:2] == `EMIF_OFS_TIMING >> 2) || (a[7:2] == `EMIF_OFS_STATUS >> 2);
    endfunction

    // Picks the first phase after the address or latch phase: setup if any, else strobe.
    function automatic logic [12:0] setup_entry(input logic [1:0] setup, input logic [3:0] pulse);
        if (setup != 2'h0) begin
            setup_entry = {emif_pkg::ST_SETUP, 2'h0, setup - 2'h1};
        end else begin
            setup_entry = {emif_pkg::ST_STROBE, pulse};
        end
    endfunction

    // Register group.
    logic [7:0] config_q, config_d;
    logic [7:0] bank_page_q, bank_page_d;
    logic [7:0] timing_q, timing_d;

    // AXI group.
    logic aw_have_q, aw_have_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic w_have_q, w_have_d;
    logic [7:0] wdata_q, wdata_d;
    logic wlane_q, wlane_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    // Access sequencer group.
    emif_pkg::state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] addr_q, addr_d;
    logic hi_drive_q, hi_drive_d;
    logic write_q, write_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic [7:0] cpu_rdata_q, cpu_rdata_d;
    logic done_q, done_d;
    logic offchip_q, offchip_d;

    logic [7:0] external_data_ram [0:`EMIF_EXTERNAL_DATA_RAM_SIZE-1];
    logic [7:0] external_data_ram_rd_q;

    logic wr_fire;
    logic muxed;
    logic [1:0] ale_len;
    logic [1:0] setup_len;
    logic [3:0] pulse_len;
    logic [1:0] hold_len;
    emif_pkg::mode_t mode;
    logic [15:0] req_addr;
    logic req_local;
    logic req_hi_drive;
    logic ext_active;
    logic mux_addr_phase;
    logic [12:0] entry;

    assign muxed = config_q[`EMIF_CFG_MUX_BIT];
    assign ale_len = config_q[`EMIF_CFG_ALE_MSB:`EMIF_CFG_ALE_LSB];
    assign mode = emif_pkg::mode_t'(config_q[`EMIF_CFG_MODE_MSB:`EMIF_CFG_MODE_LSB]);
    assign setup_len = timing_q[`EMIF_TC_SETUP_MSB:`EMIF_TC_SETUP_LSB];
    assign pulse_len = timing_q[`EMIF_TC_PULSE_MSB:`EMIF_TC_PULSE_LSB];
    assign hold_len = timing_q[`EMIF_TC_HOLD_MSB:`EMIF_TC_HOLD_LSB];
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // Address that decides the route: byte moves use the bank page as upper byte.
    assign req_addr = CPU_WIDE ? CPU_DATA_POINTER : {bank_page_q, CPU_INDIRECT_POINTER};

    always_comb begin
        unique case (mode)
            emif_pkg::MODE_ONCHIP: req_local = 1'b1;
            emif_pkg::MODE_EXTERNAL: req_local = 1'b0;
            default: req_local = {1'b0, req_addr} < `EMIF_EXTERNAL_DATA_RAM_SIZE;
        endcase
    end

    // Without bank select, or in external-only mode, byte moves leave the high byte to the port.
    assign req_hi_drive = CPU_WIDE || (mode == emif_pkg::MODE_SPLIT_BANK);

    always_comb begin
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_d = 1'b1;
            awaddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_d = 1'b1;
            wdata_d = S_AXI_WDATA[7:0];
            wlane_d = S_AXI_WSTRB[0];
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = offset_known(awaddr_q) ? `EMIF_RESP_OKAY : `EMIF_RESP_SLVERR;
        end
        if (bvalid_q && S_AXI_BREADY) begin
            bvalid_d = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_d = 1'b1;
            rresp_d = offset_known(S_AXI_ARADDR) ? `EMIF_RESP_OKAY : `EMIF_RESP_SLVERR;
            rdata_d = 32'h0000_0000;
            unique case (S_AXI_ARADDR[7:2])
                `EMIF_OFS_CONFIG >> 2: rdata_d[7:0] = config_q;
                `EMIF_OFS_BANK_PAGE >> 2: rdata_d[7:0] = bank_page_q;
                `EMIF_OFS_TIMING >> 2: rdata_d[7:0] = timing_q;
                `EMIF_OFS_STATUS >> 2: rdata_d[1:0] = {state_q != emif_pkg::ST_IDLE, offchip_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_have_q <= 1'b0;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `EMIF_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `EMIF_RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            awaddr_q <= awaddr_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wlane_q <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
    assign S_AXI_WREADY = !w_have_q && !bvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // Settings are read live, so software must not change them while an access runs.
    always_comb begin
        config_d = config_q;
        bank_page_d = bank_page_q;
        timing_d = timing_q;
        if (wr_fire && wlane_q) begin
            unique case (awaddr_q[7:2])
                `EMIF_OFS_CONFIG >> 2: config_d = {3'h0, wdata_q[4:0]};
                `EMIF_OFS_BANK_PAGE >> 2: bank_page_d = wdata_q;
                `EMIF_OFS_TIMING >> 2: timing_d = wdata_q;
                default: config_d = config_q;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            config_q <= `EMIF_RST_CONFIG;
            bank_page_q <= `EMIF_RST_BANK_PAGE;
            timing_q <= `EMIF_RST_TIMING;
        end else begin
            config_q <= config_d;
            bank_page_q <= bank_page_d;
            timing_q <= timing_d;
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        hi_drive_d = hi_drive_q;
        write_d = write_q;
        wbyte_d = wbyte_q;
        cpu_rdata_d = cpu_rdata_q;
        done_d = 1'b0;
        offchip_d = offchip_q;
        entry = setup_entry(setup_len, pulse_len);
        unique case (state_q)
            emif_pkg::ST_IDLE: begin
                if (CPU_REQ) begin
                    addr_d = CPU_WIDE ? CPU_DATA_POINTER : {bank_page_q, CPU_INDIRECT_POINTER};
                    hi_drive_d = req_hi_drive;
                    write_d = CPU_WRITE;
                    wbyte_d = CPU_WDATA;
                    offchip_d = !req_local;
                    state_d = req_local ? emif_pkg::ST_LOCAL : emif_pkg::ST_ADDR;
                end
            end
            emif_pkg::ST_LOCAL: begin
                if (!write_q) begin
                    cpu_rdata_d = external_data_ram_rd_q;
                end
                done_d = 1'b1;
                state_d = emif_pkg::ST_IDLE;
            end
            emif_pkg::ST_ADDR: begin
                if (muxed) begin
                    state_d = emif_pkg::ST_ALEH;
                    cnt_d = {2'h0, ale_len};
                end else begin
                    state_d = emif_pkg::state_t'(entry[12:4]);
                    cnt_d = entry[3:0];
                end
            end
            emif_pkg::ST_ALEH: begin
                if (cnt_q == 4'h0) begin
                    state_d = emif_pkg::ST_ALEL;
                    cnt_d = {2'h0, ale_len};
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            emif_pkg::ST_ALEL: begin
                if (cnt_q == 4'h0) begin
                    state_d = emif_pkg::state_t'(entry[12:4]);
                    cnt_d = entry[3:0];
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            emif_pkg::ST_SETUP: begin
                if (cnt_q == 4'h0) begin
                    state_d = emif_pkg::ST_STROBE;
                    cnt_d = pulse_len;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            emif_pkg::ST_STROBE: begin
                if (cnt_q == 4'h0) begin
                    if (!write_q) begin
                        cpu_rdata_d = EXT_DATA_I;
                    end
                    state_d = (hold_len != 2'h0) ? emif_pkg::ST_HOLD : emif_pkg::ST_TAIL;
                    cnt_d = (hold_len != 2'h0) ? {2'h0, hold_len - 2'h1} : `EMIF_TAIL_LOAD;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            emif_pkg::ST_HOLD: begin
                if (cnt_q == 4'h0) begin
                    state_d = emif_pkg::ST_TAIL;
                    cnt_d = `EMIF_TAIL_LOAD;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            emif_pkg::ST_TAIL: begin
                // Address cycle plus these three cycles make the fixed overhead.
                if (cnt_q == 4'h0) begin
                    done_d = 1'b1;
                    state_d = emif_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: state_d = emif_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= emif_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            addr_q <= 16'h0000;
            hi_drive_q <= 1'b0;
            write_q <= 1'b0;
            wbyte_q <= 8'h00;
            cpu_rdata_q <= 8'h00;
            done_q <= 1'b0;
            offchip_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            hi_drive_q <= hi_drive_d;
            write_q <= write_d;
            wbyte_q <= wbyte_d;
            cpu_rdata_q <= cpu_rdata_d;
            done_q <= done_d;
            offchip_q <= offchip_d;
        end
    end

    // Write lands on the edge that enters the local state; read data follows one cycle later.
    always_ff @(posedge CLOCK) begin
        if (state_q == emif_pkg::ST_IDLE && CPU_REQ && req_local && CPU_WRITE) begin
            external_data_ram[req_addr[`EMIF_EXTERNAL_DATA_RAM_AW-1:0]] <= CPU_WDATA;
        end
        external_data_ram_rd_q <= external_data_ram[req_addr[`EMIF_EXTERNAL_DATA_RAM_AW-1:0]];
    end

    assign CPU_READY = (state_q == emif_pkg::ST_IDLE);
    assign CPU_DONE = done_q;
    assign CPU_RDATA = cpu_rdata_q;

    assign ext_active = (state_q != emif_pkg::ST_IDLE) && (state_q != emif_pkg::ST_LOCAL);
    assign mux_addr_phase = muxed && ((state_q == emif_pkg::ST_ADDR)
        || (state_q == emif_pkg::ST_ALEH) || (state_q == emif_pkg::ST_ALEL));

    assign EXT_ADDR_HI = addr_q[15:8];
    assign EXT_ADDR_HI_OE = ext_active && hi_drive_q;
    assign EXT_ADDR_LO = addr_q[7:0];
    assign EXT_ADDR_LO_OE = ext_active && !muxed;
    // In multiplexed mode the low address byte shares the data lines until the ALE-low phase ends.
    assign EXT_DATA_O = mux_addr_phase ? addr_q[7:0] : wbyte_q;
    assign EXT_DATA_OE = mux_addr_phase || (ext_active && write_q);
    assign EXT_ALE = (state_q == emif_pkg::ST_ALEH);
    assign EXT_RD_N = !((state_q == emif_pkg::ST_STROBE) && !write_q);
    assign EXT_WR_N = !((state_q == emif_pkg::ST_STROBE) && write_q);

endmodule

`default_nettype wire
